// *** rtl/dmc_cycle_ctrl.sv ***
// Read, write and refresh cycle control for the dynamic memory card
// Functional notes
// - Read start presents address bits 7..12 as row, picking one of 64.
// - After row, row_time switches mux to bits 1..6, then column strobe.
// - Word read enables both output halves, low byte through swap.
// - Byte read enables low half only; select bit picks stored byte.
// - Release of address valid drops acknowledge, enables, frees control.
// - Power-up clear pulse resets cycle timing and refresh state.
// - Word write stores 16 bits; byte write steers the selected byte.
// - Top four address lines must match switches to enable the card.
// - Row phase, no refresh, feeds address bits 7..12 as row.
// - Falling address valid on matching card starts one cycle only.
// - 7-bit refresh counter; bit 0 is tick, upper six are row.
// - Rising tick starts refresh when idle, else after current cycle.
// - Refresh holds refresh_active_n low, ignores requests, muxes counter.
// - Refresh drives both row and column strobes, no write or enable.
// - Refresh ends releasing strobes and refresh_active_n.
// - Refreshes step all 64 rows within two milliseconds, then wrap.
// - Address bit 13 high strobes page 0, low strobes page 1.
// - Word write pulses both write strobes; byte write pulses one.
// - Bus timeout asserted when a requested cycle cannot complete.
// - Refresh oscillator runs at 123.33 kHz.
`timescale 1ns/1ps
module dmc_cycle_ctrl #(
  parameter int TIMEOUT_CYC = dmc_pkg::DEF_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // Processor bus inputs
  input  wire logic [17:0] BUS_ADDR_LINES,
  input  wire logic [15:0] BUS_DATA_IN,
  input  wire logic        ADDR_VALID_N,
  input  wire logic        WRITE_CMD_N,
  input  wire logic        BYTE_MODE_N,
  input  wire logic        POWERUP_CLEAR_N,
  input  wire logic [3:0]  CARD_SWITCH,
  // Processor bus outputs
  output logic      [15:0] BUS_DATA_OUT,
  output logic             LOW_OUT_EN_N,
  output logic             HIGH_OUT_EN_N,
  output logic             MEM_ACK_N,
  output logic             BUS_TIMEOUT_N,
  // Storage array
  input  wire logic [15:0] MEM_RD_DATA,
  output logic      [15:0] MEM_WR_DATA,
  output logic      [5:0]  DRAM_ROW_COL_ADDR,
  output logic      [1:0]  ROW_STROBE_N,
  output logic      [1:0]  COL_STROBE_N,
  output logic             ROW_TIME,
  output logic             REFRESH_ACTIVE_N,
  output logic             WRITE_LOW_N,
  output logic             WRITE_HIGH_N
);
  localparam logic [15:0] TOC_LAST = 16'(TIMEOUT_CYC - 1);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a bit changes once stages two and three agree
  logic [dmc_pkg::PIN_W-1:0] pin_in;
  logic [dmc_pkg::PIN_W-1:0] s1_r, s2_r, s3_r, flt_r, flt_nxt;

  assign pin_in = {BUS_ADDR_LINES, BUS_DATA_IN, ADDR_VALID_N, WRITE_CMD_N,
                   BYTE_MODE_N, POWERUP_CLEAR_N, CARD_SWITCH};

  always_comb begin
    flt_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & flt_r);
  end

  // Idle bus lines are high, so everything resets high
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s1_r  <= '1;
      s2_r  <= '1;
      s3_r  <= '1;
      flt_r <= '1;
    end else begin
      s1_r  <= pin_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      flt_r <= flt_nxt;
    end
  end

  logic [17:0] addr;
  logic [15:0] wdata;
  logic        av_on, wr_on, byte_on, pclr, card_hit;

  assign addr    = flt_r[dmc_pkg::PIN_ADDR_LSB +: dmc_pkg::ADDR_W];
  assign wdata   = flt_r[dmc_pkg::PIN_DATA_LSB +: dmc_pkg::DATA_W];
  assign av_on   = !flt_r[dmc_pkg::PIN_AV];
  assign wr_on   = !flt_r[dmc_pkg::PIN_WR];
  assign byte_on = !flt_r[dmc_pkg::PIN_BYTE];
  assign pclr    = !flt_r[dmc_pkg::PIN_PCLR];
  assign card_hit = addr[dmc_pkg::CARD_LSB +: dmc_pkg::CARD_W] ==
                    flt_r[dmc_pkg::CARD_W-1:0];

  //////////////////////////////////////////////////////////////////////////
  // Refresh timing
  logic       ref_tick, ref_tick_r;
  logic [5:0] ref_row;

  dmc_refresh_gen u_refresh (
    .clk          (CORE_CLK),
    .rst          (RST),
    .clr          (pclr),
    .refresh_osc  (),
    .refresh_tick (ref_tick),
    .refresh_row  (ref_row)
  );

  // Byte steering toward the bus; select high returns the stored low byte
  function automatic logic [15:0] out_swap(input logic [15:0] d,
                                           input logic        bmode,
                                           input logic        bsel);
    if (!bmode) begin
      out_swap = d;
    end else begin
      out_swap = bsel ? {8'h00, d[7:0]} : {8'h00, d[15:8]};
    end
  endfunction : out_swap

  // Byte steering toward the array; the byte goes to both lanes so the
  // one write strobe that fires always sees it
  function automatic logic [15:0] in_swap(input logic [15:0] d,
                                          input logic        bmode,
                                          input logic        bsel);
    if (!bmode) begin
      in_swap = d;
    end else begin
      in_swap = bsel ? {d[15:8], d[15:8]} : {d[7:0], d[7:0]};
    end
  endfunction : in_swap

  //////////////////////////////////////////////////////////////////////////
  // Cycle sequencer
  dmc_pkg::dmc_state_t state_r, state_nxt;
  logic [7:0]  tmr_r, tmr_nxt;
  logic [15:0] toc_r, toc_nxt;
  logic        pend_r, pend_nxt;
  logic        served_r, served_nxt;
  logic        cwr_r, cwr_nxt, cbyte_r, cbyte_nxt;
  logic        csel_r, csel_nxt, cpage_r, cpage_nxt;
  logic        tick_rise, done, req, counting;

  assign tick_rise = ref_tick && !ref_tick_r;
  assign done      = (tmr_r == 8'h00);
  // Level plus served flag gives one cycle per falling address valid
  assign req       = av_on && card_hit && !served_r;
  assign counting  = (state_r == dmc_pkg::ST_IDLE && req) ||
                     state_r inside {dmc_pkg::ST_ROW, dmc_pkg::ST_MUX,
                                     dmc_pkg::ST_COL, dmc_pkg::ST_SETTLE};

  always_comb begin
    state_nxt  = state_r;
    tmr_nxt    = done ? tmr_r : 8'(tmr_r - 8'h01);
    toc_nxt    = counting ? 16'(toc_r + 16'h0001) : 16'h0000;
    pend_nxt   = pend_r || tick_rise;
    served_nxt = served_r && av_on;
    cwr_nxt    = cwr_r;
    cbyte_nxt  = cbyte_r;
    csel_nxt   = csel_r;
    cpage_nxt  = cpage_r;
    case (state_r)
      dmc_pkg::ST_IDLE: begin
        // Refresh first; a waiting request is served right after it
        if (pend_r) begin
          state_nxt = dmc_pkg::ST_REF;
          tmr_nxt   = dmc_pkg::REF_CYC;
          pend_nxt  = tick_rise;
        end else if (req && counting && toc_r == TOC_LAST) begin
          state_nxt  = dmc_pkg::ST_FAIL;
          served_nxt = 1'b1;
        end else if (req) begin
          state_nxt  = dmc_pkg::ST_ROW;
          tmr_nxt    = dmc_pkg::ROW_CYC;
          served_nxt = 1'b1;
          cwr_nxt    = wr_on;
          cbyte_nxt  = byte_on;
          csel_nxt   = addr[dmc_pkg::BYTE_SEL_BIT];
          cpage_nxt  = addr[dmc_pkg::PAGE_BIT];
        end
      end
      dmc_pkg::ST_ROW: begin
        if (done) begin
          state_nxt = dmc_pkg::ST_MUX;
          tmr_nxt   = dmc_pkg::MUX_CYC;
        end
      end
      dmc_pkg::ST_MUX: begin
        if (done) begin
          state_nxt = dmc_pkg::ST_COL;
          tmr_nxt   = dmc_pkg::COL_CYC;
        end
      end
      dmc_pkg::ST_COL: begin
        if (done) begin
          state_nxt = cwr_r ? dmc_pkg::ST_ACK : dmc_pkg::ST_SETTLE;
          tmr_nxt   = dmc_pkg::SET_CYC;
        end
      end
      dmc_pkg::ST_SETTLE: begin
        if (done) begin
          state_nxt = dmc_pkg::ST_ACK;
        end
      end
      dmc_pkg::ST_ACK: begin
        if (!av_on) begin
          state_nxt = dmc_pkg::ST_IDLE;
        end
      end
      dmc_pkg::ST_REF: begin
        if (done) begin
          state_nxt = dmc_pkg::ST_IDLE;
        end
      end
      dmc_pkg::ST_FAIL: begin
        if (!av_on) begin
          state_nxt = dmc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = dmc_pkg::ST_IDLE;
      end
    endcase
    // Timeout can strike in the row, mux, column or settle step of a read or write
    if (counting && toc_r == TOC_LAST &&
        state_r != dmc_pkg::ST_IDLE) begin
      state_nxt = dmc_pkg::ST_FAIL;
    end
    if (pclr) begin
      state_nxt  = dmc_pkg::ST_IDLE;
      tmr_nxt    = 8'h00;
      toc_nxt    = 16'h0000;
      pend_nxt   = 1'b0;
      served_nxt = av_on;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output decode from the next state, read data from the current one, so every output is a flip-flop
  logic [15:0] dout_nxt, mwd_nxt;
  logic [5:0]  maddr_nxt;
  logic [1:0]  ras_nxt, cas_nxt;
  logic        row_time_nxt, refn_nxt, wrl_nxt, wrh_nxt;
  logic        oel_nxt, oeh_nxt, ack_nxt, tmo_nxt;
  logic        in_row, in_col, rd_out;

  always_comb begin
    in_row = state_nxt inside {dmc_pkg::ST_ROW, dmc_pkg::ST_MUX,
                               dmc_pkg::ST_COL};
    in_col = state_nxt inside {dmc_pkg::ST_MUX, dmc_pkg::ST_COL};
    rd_out = !cwr_nxt && state_nxt inside {dmc_pkg::ST_COL,
                       dmc_pkg::ST_SETTLE, dmc_pkg::ST_ACK};
    row_time_nxt = !in_col;
    refn_nxt = state_nxt != dmc_pkg::ST_REF;
    if (!refn_nxt) begin
      maddr_nxt = ref_row;
    end else if (!row_time_nxt) begin
      maddr_nxt = addr[dmc_pkg::COL_LSB +: dmc_pkg::MUX_W];
    end else begin
      maddr_nxt = addr[dmc_pkg::ROW_LSB +: dmc_pkg::MUX_W];
    end
    if (!refn_nxt) begin
      ras_nxt = 2'b00;
    end else if (in_row) begin
      ras_nxt = cpage_nxt ? 2'b10 : 2'b01;
    end else begin
      ras_nxt = 2'b11;
    end
    cas_nxt = (!refn_nxt || state_nxt == dmc_pkg::ST_COL) ?
              2'b00 : 2'b11;
    wrl_nxt = 1'b1;
    wrh_nxt = 1'b1;
    if (cwr_nxt && state_nxt == dmc_pkg::ST_COL) begin
      wrl_nxt = cbyte_nxt && !csel_nxt;
      wrh_nxt = cbyte_nxt && csel_nxt;
    end
    oel_nxt  = !rd_out;
    oeh_nxt  = !(rd_out && !cbyte_nxt);
    ack_nxt  = state_nxt != dmc_pkg::ST_ACK;
    tmo_nxt  = state_nxt != dmc_pkg::ST_FAIL;
    dout_nxt = BUS_DATA_OUT;
    if (!cwr_r && state_r == dmc_pkg::ST_COL) begin
      dout_nxt = out_swap(MEM_RD_DATA, cbyte_r, csel_r);
    end
    mwd_nxt = in_swap(wdata, cbyte_nxt, csel_nxt);
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_r           <= dmc_pkg::ST_IDLE;
      tmr_r             <= 8'h00;
      toc_r             <= 16'h0000;
      pend_r            <= 1'b0;
      served_r          <= 1'b0;
      ref_tick_r        <= 1'b0;
      cwr_r             <= 1'b0;
      cbyte_r           <= 1'b0;
      csel_r            <= 1'b0;
      cpage_r           <= 1'b0;
      BUS_DATA_OUT      <= 16'h0000;
      MEM_WR_DATA       <= 16'h0000;
      DRAM_ROW_COL_ADDR <= 6'h00;
      ROW_STROBE_N      <= 2'h3;
      COL_STROBE_N      <= 2'h3;
      ROW_TIME          <= 1'b1;
      REFRESH_ACTIVE_N  <= 1'b1;
      WRITE_LOW_N       <= 1'b1;
      WRITE_HIGH_N      <= 1'b1;
      LOW_OUT_EN_N      <= 1'b1;
      HIGH_OUT_EN_N     <= 1'b1;
      MEM_ACK_N         <= 1'b1;
      BUS_TIMEOUT_N     <= 1'b1;
    end else begin
      state_r           <= state_nxt;
      tmr_r             <= tmr_nxt;
      toc_r             <= toc_nxt;
      pend_r            <= pend_nxt;
      served_r          <= served_nxt;
      ref_tick_r        <= ref_tick;
      cwr_r             <= cwr_nxt;
      cbyte_r           <= cbyte_nxt;
      csel_r            <= csel_nxt;
      cpage_r           <= cpage_nxt;
      BUS_DATA_OUT      <= dout_nxt;
      MEM_WR_DATA       <= mwd_nxt;
      DRAM_ROW_COL_ADDR <= maddr_nxt;
      ROW_STROBE_N      <= ras_nxt;
      COL_STROBE_N      <= cas_nxt;
      ROW_TIME          <= row_time_nxt;
      REFRESH_ACTIVE_N  <= refn_nxt;
      WRITE_LOW_N       <= wrl_nxt;
      WRITE_HIGH_N      <= wrh_nxt;
      LOW_OUT_EN_N      <= oel_nxt;
      HIGH_OUT_EN_N     <= oeh_nxt;
      MEM_ACK_N         <= ack_nxt;
      BUS_TIMEOUT_N     <= tmo_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  chk_row_addr: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(state_r == dmc_pkg::ST_ROW) |-> ROW_TIME &&
      DRAM_ROW_COL_ADDR == $past(addr[12:7]))
    else $error("row address not from bits 7 to 12");
  chk_col_phase: assert property (@(posedge CORE_CLK) disable iff (RST)
    state_r == dmc_pkg::ST_ROW && state_nxt == dmc_pkg::ST_MUX
      |=> !ROW_TIME && COL_STROBE_N == 2'b11 ##[1:8] COL_STROBE_N == 2'b00)
    else $error("column phase order wrong");
  chk_read_en: assert property (@(posedge CORE_CLK) disable iff (RST)
    state_r == dmc_pkg::ST_SETTLE |-> !LOW_OUT_EN_N &&
      (HIGH_OUT_EN_N == cbyte_r))
    else $error("read output enables wrong");
  chk_ack_settle: assert property (@(posedge CORE_CLK) disable iff (RST)
    $fell(MEM_ACK_N) && !cwr_r |->
      $past(state_r, 1) == dmc_pkg::ST_SETTLE && !LOW_OUT_EN_N)
    else $error("read acknowledged before settling");
  chk_release: assert property (@(posedge CORE_CLK) disable iff (RST)
    state_r == dmc_pkg::ST_ACK && !av_on && !pclr |=>
      MEM_ACK_N && LOW_OUT_EN_N && HIGH_OUT_EN_N)
    else $error("release did not end the cycle");
  chk_card_hit: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(state_r == dmc_pkg::ST_ROW) |-> $past(card_hit) && $past(av_on))
    else $error("cycle started on unaddressed card");
  chk_ref_start: assert property (@(posedge CORE_CLK) disable iff (RST)
    pend_r && state_r == dmc_pkg::ST_IDLE && !pclr |=>
      state_r == dmc_pkg::ST_REF)
    else $error("pending refresh not started");
  chk_ref_strobe: assert property (@(posedge CORE_CLK) disable iff (RST)
    state_r == dmc_pkg::ST_REF |-> !REFRESH_ACTIVE_N &&
      ROW_STROBE_N == 2'b00 && COL_STROBE_N == 2'b00 && WRITE_LOW_N &&
      WRITE_HIGH_N && LOW_OUT_EN_N && HIGH_OUT_EN_N)
    else $error("refresh strobes wrong");
  chk_ref_end: assert property (@(posedge CORE_CLK) disable iff (RST)
    $fell(state_r == dmc_pkg::ST_REF) |-> REFRESH_ACTIVE_N &&
      ROW_STROBE_N == 2'b11 && COL_STROBE_N == 2'b11)
    else $error("refresh end did not release strobes");
  chk_page_sel: assert property (@(posedge CORE_CLK) disable iff (RST)
    state_r == dmc_pkg::ST_ROW |-> ROW_STROBE_N == {cpage_r, !cpage_r})
    else $error("wrong page strobed");
  chk_wr_strobe: assert property (@(posedge CORE_CLK) disable iff (RST)
    state_r == dmc_pkg::ST_COL && cwr_r |->
      (!WRITE_LOW_N != (cbyte_r && !csel_r)) &&
      (!WRITE_HIGH_N != (cbyte_r && csel_r)))
    else $error("write strobes wrong");
  chk_timeout: assert property (@(posedge CORE_CLK) disable iff (RST)
    $fell(BUS_TIMEOUT_N) |-> $past(toc_r) == TOC_LAST)
    else $error("timeout at wrong count");
  chk_pclr: assert property (@(posedge CORE_CLK) disable iff (RST)
    pclr |=> state_r == dmc_pkg::ST_IDLE && !pend_r)
    else $error("power-up clear ignored");
endmodule : dmc_cycle_ctrl

// *** rtl/dmc_pkg.sv ***
// Constants, field positions and state codes for the memory card cycle control
package dmc_pkg;
  // Clock and time base
  localparam int  CLK_FREQ_KHZ   = 40000;
  localparam int  CLK_PERIOD_NS  = 25;
  localparam real OSC_FREQ_KHZ   = 123.33;
  // Half period of the refresh oscillator, a longest time, rounded down
  localparam int  OSC_HALF_CYC   =
    int'($floor(real'(CLK_FREQ_KHZ) / (2.0 * OSC_FREQ_KHZ)));

  // Strobe timing, least times, rounded up to whole cycles
  localparam int  T_ROW_SETUP_NS = 100;
  localparam int  T_COL_SETUP_NS = 50;
  localparam int  T_COL_HOLD_NS  = 150;
  localparam int  T_SETTLE_NS    = 100;
  localparam int  T_REF_NS       = 250;
  localparam logic [7:0] ROW_CYC =
    8'((T_ROW_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] MUX_CYC =
    8'((T_COL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] COL_CYC =
    8'((T_COL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SET_CYC =
    8'((T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] REF_CYC =
    8'((T_REF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int  DEF_TIMEOUT_CYC = 400;

  // Widths
  localparam int  ADDR_W    = 18;
  localparam int  DATA_W    = 16;
  localparam int  MUX_W     = 6;
  localparam int  REF_CNT_W = 7;
  localparam int  CARD_W    = 4;

  // Bus address fields
  localparam int  BYTE_SEL_BIT = 0;
  localparam int  COL_LSB      = 1;
  localparam int  ROW_LSB      = 7;
  localparam int  PAGE_BIT     = 13;
  localparam int  CARD_LSB     = 14;

  // Layout of the synchronised pin vector
  localparam int  PIN_W        = ADDR_W + DATA_W + 4 + CARD_W;
  localparam int  PIN_ADDR_LSB = DATA_W + 4 + CARD_W;
  localparam int  PIN_DATA_LSB = 4 + CARD_W;
  localparam int  PIN_AV       = CARD_W + 3;
  localparam int  PIN_WR       = CARD_W + 2;
  localparam int  PIN_BYTE     = CARD_W + 1;
  localparam int  PIN_PCLR     = CARD_W;

  // Reset values
  localparam logic [REF_CNT_W-1:0] REF_CNT_RST = 7'h00;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_ROW    = 8'h02,
    ST_MUX    = 8'h04,
    ST_COL    = 8'h08,
    ST_SETTLE = 8'h10,
    ST_ACK    = 8'h20,
    ST_REF    = 8'h40,
    ST_FAIL   = 8'h80
  } dmc_state_t;
endpackage : dmc_pkg

// *** rtl/dmc_refresh_gen.sv ***
// Refresh oscillator divider and 7-bit refresh counter
`timescale 1ns/1ps
module dmc_refresh_gen (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clr,
  // Refresh timing
  output logic            refresh_osc,
  output logic            refresh_tick,
  output logic [5:0]      refresh_row
);
  logic [7:0] div_r, div_nxt;
  logic       osc_r, osc_nxt;
  logic [6:0] cnt_r, cnt_nxt;
  logic       osc_rise;

  assign osc_rise     = (div_r == 8'(dmc_pkg::OSC_HALF_CYC - 1)) && !osc_r;
  assign refresh_osc  = osc_r;
  assign refresh_tick = cnt_r[0];
  assign refresh_row  = cnt_r[6:1];

  always_comb begin
    div_nxt = 8'(div_r + 8'h01);
    osc_nxt = osc_r;
    cnt_nxt = cnt_r;
    if (div_r == 8'(dmc_pkg::OSC_HALF_CYC - 1)) begin
      div_nxt = 8'h00;
      osc_nxt = !osc_r;
    end
    // Free-running: wraps 127 to 0, so rows step 0..63 forever
    if (osc_rise) begin
      cnt_nxt = 7'(cnt_r + 7'h01);
    end
    if (clr) begin
      div_nxt = 8'h00;
      osc_nxt = 1'b0;
      cnt_nxt = dmc_pkg::REF_CNT_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_r <= 8'h00;
      osc_r <= 1'b0;
      cnt_r <= dmc_pkg::REF_CNT_RST;
    end else begin
      div_r <= div_nxt;
      osc_r <= osc_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  chk_cnt_step: assert property (@(posedge clk) disable iff (rst)
    osc_rise && !clr |=> cnt_r == 7'($past(cnt_r) + 7'h01))
    else $error("refresh counter did not step");
  chk_osc_half: assert property (@(posedge clk)
    disable iff (rst || clr)
    $rose(osc_r) && !clr |=> osc_r [*8])
    else $error("refresh oscillator half period too short");
endmodule : dmc_refresh_gen

// *** test/dmc_bus_master.sv ***
// Bus master card model running address-valid handshake cycles
`timescale 1ns/1ps
module dmc_bus_master (
  // Clock
  input  wire logic        clk,
  // Answers from the card
  input  wire logic        ack_n,
  input  wire logic [1:0]  en_n,
  input  wire logic [15:0] rd_data,
  // Requests to the card
  output logic      [17:0] addr,
  output logic      [15:0] data,
  output logic             av_n,
  output logic             wr_n,
  output logic             byte_n
);
  initial begin
    addr   = 18'h00000;
    data   = 16'h0000;
    av_n   = 1'b1;
    wr_n   = 1'b1;
    byte_n = 1'b1;
  end

  // Caller enters just after an edge; a held request never changes
  task automatic xfer(input logic [17:0] a, input logic w, input logic b,
                      input logic [15:0] d, output logic [15:0] q,
                      output logic [1:0] en, output logic ok,
                      output logic rel);
    int n;
    addr   = a;
    data   = d;
    byte_n = ~b;
    @(posedge clk) #1 wr_n = ~w;
    @(posedge clk) #1 av_n = 1'b0;
    ok = 1'b0;
    q  = 16'h0000;
    en = 2'b11;
    n  = 0;
    while (!ok && n < 60) begin
      @(posedge clk) #1;
      n++;
      if (ack_n === 1'b0) begin
        ok = 1'b1;
        q  = rd_data;
        en = en_n;
      end
    end
    av_n = 1'b1;
    wr_n = 1'b1;
    data = ~d;
    rel  = 1'b0;
    for (n = 0; n < 8 && !rel; n++) begin
      @(posedge clk) #1;
      rel = (ack_n === 1'b1) && (en_n === 2'b11);
    end
  endtask : xfer
endmodule : dmc_bus_master

// *** test/dmc_cycle_ctrl_tb.sv ***
// Self-checking bench for the memory card cycle control
`timescale 1ns/1ps
module dmc_cycle_ctrl_tb;
  logic clk, rst, av_n, wr_n, byte_n, ok, rel, lo_n, hi_n, ack_n, to_n;
  logic [17:0] addr;
  logic [15:0] data, dout, wdat, mem, q;
  logic [1:0]  en, rs_n, cs_n, rs_seen, wr_seen;
  logic [5:0]  ra, row_seen, col_seen;
  logic        rt, ref_n, wl_n, wh_n, pclr_n;
  int          n_fail, cmp_count, cyc;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  dmc_cycle_ctrl #(.TIMEOUT_CYC(40)) u_dut (
    .CORE_CLK(clk), .RST(rst), .BUS_ADDR_LINES(addr), .BUS_DATA_IN(data),
    .ADDR_VALID_N(av_n), .WRITE_CMD_N(wr_n), .BYTE_MODE_N(byte_n),
    .POWERUP_CLEAR_N(pclr_n), .CARD_SWITCH(4'hA), .BUS_DATA_OUT(dout),
    .LOW_OUT_EN_N(lo_n), .HIGH_OUT_EN_N(hi_n), .MEM_ACK_N(ack_n),
    .BUS_TIMEOUT_N(to_n), .MEM_RD_DATA(mem), .MEM_WR_DATA(wdat),
    .DRAM_ROW_COL_ADDR(ra), .ROW_STROBE_N(rs_n), .COL_STROBE_N(cs_n),
    .ROW_TIME(rt), .REFRESH_ACTIVE_N(ref_n), .WRITE_LOW_N(wl_n),
    .WRITE_HIGH_N(wh_n));

  dmc_bus_master u_master (
    .clk(clk), .ack_n(ack_n), .en_n({hi_n, lo_n}), .rd_data(dout),
    .addr(addr), .data(data), .av_n(av_n), .wr_n(wr_n), .byte_n(byte_n));

  // One-word array stand-in; monitors record strobes of bus cycles only
  always @(posedge clk) begin
    if (wl_n === 1'b0) mem[7:0] <= wdat[7:0];
    if (wh_n === 1'b0) mem[15:8] <= wdat[15:8];
    if (ref_n === 1'b1 && rs_n !== 2'b11) rs_seen <= rs_n;
    if (ref_n === 1'b1 && rt === 1'b1 && rs_n !== 2'b11) row_seen <= ra;
    if (ref_n === 1'b1 && rt === 1'b0 && cs_n === 2'b00) col_seen <= ra;
    wr_seen <= wr_seen | ~{wh_n, wl_n};
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic go(input logic [17:0] a, input logic w, input logic b,
                    input logic [15:0] d);
    rs_seen = 2'b11;
    wr_seen = 2'b00;
    u_master.xfer(a, w, b, d, q, en, ok, rel);
  endtask : go

  task automatic t_word;
    go({4'hA, 1'b1, 12'h2C9, 1'b0}, 1'b1, 1'b0, 16'h5AC3);
    chk(16'(ok), 16'h0001);
    chk(16'(rs_seen), 16'h0002);
    chk(16'(wr_seen), 16'h0003);
    chk(16'(row_seen), 16'h000B);
    chk(16'(col_seen), 16'h0009);
    go({4'hA, 1'b1, 12'h2C9, 1'b0}, 1'b0, 1'b0, 16'h0000);
    chk(q, 16'h5AC3);
    chk(16'(en), 16'h0000);
    chk(16'(rel), 16'h0001);
    chk(16'(wr_seen), 16'h0000);
    $display("word test done");
  endtask : t_word

  task automatic t_byte;
    go({4'hA, 1'b0, 12'h2C9, 1'b0}, 1'b1, 1'b1, 16'h33AB);
    chk(16'(rs_seen), 16'h0001);
    chk(16'(wr_seen), 16'h0002);
    chk(mem, 16'hABC3);
    go({4'hA, 1'b0, 12'h2C9, 1'b1}, 1'b0, 1'b1, 16'h0000);
    chk(16'(q[7:0]), 16'h00C3);
    chk(16'(en), 16'h0002);
    go({4'hA, 1'b0, 12'h2C9, 1'b0}, 1'b0, 1'b1, 16'h0000);
    chk(16'(q[7:0]), 16'h00AB);
    chk(16'(rel), 16'h0001);
    $display("byte test done");
  endtask : t_byte

  task automatic t_other;
    go({4'h5, 1'b1, 12'h2C9, 1'b0}, 1'b0, 1'b0, 16'h0000);
    chk(16'(ok), 16'h0000);
    chk(16'(to_n), 16'h0001);
    $display("other card test done");
  endtask : t_other

  task automatic t_refresh;
    logic [5:0] r0;
    int         i;
    for (int k = 0; k < 2; k++) begin
      for (i = 0; i < 1400 && ref_n !== 1'b0; i++) @(posedge clk);
      @(posedge clk) #1;
      chk(16'(i < 1400), 16'h0001);
      chk(16'({rs_n, cs_n, wh_n, wl_n, hi_n, lo_n}), 16'h000F);
      if (k == 1) chk(16'(ra), 16'(r0 + 6'h01));
      r0 = ra;
      for (i = 0; i < 40 && ref_n !== 1'b1; i++) @(posedge clk);
      #1 chk(16'({rs_n, cs_n}), 16'h000F);
    end
    $display("refresh test done");
  endtask : t_refresh

  // Clear restarts the counter, so the first refresh after it uses row 0
  task automatic t_clear;
    int i;
    pclr_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 pclr_n = 1'b1;
    for (i = 0; i < 400 && ref_n !== 1'b0; i++) @(posedge clk);
    #1 chk(16'(i > 150 && i < 200), 16'h0001);
    chk(16'(ra), 16'h0000);
    $display("clear test done");
  endtask : t_clear

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    n_fail    = 0;
    cmp_count = 0;
    cyc       = 0;
    mem       = 16'h0000;
    pclr_n    = 1'b1;
    rst       = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    t_word();
    t_byte();
    t_other();
    t_refresh();
    t_clear();
    print_verdict();
  end
endmodule : dmc_cycle_ctrl_tb
